// ---- pss_bus_masters.sv ----
// Purpose: Behavioural bus masters facing one segment arbiter
// Assumes: Active-low request and grant in the core clock domain
// Notes:   Owns the bus HOLD cycles, then backs off before asking again
`timescale 1ns/1ps
`default_nettype none
module pss_bus_masters #(
    parameter int unsigned N    = 5, // Masters
    parameter int unsigned HOLD = 4  // Cycles owned
) (
    input  wire logic         core_clk, // Core clock
    input  wire logic         resetn,   // Sync reset
    input  wire logic [N-1:0] want,     // Bench asks to request
    input  wire logic [N-1:0] gnt_n,    // Grants
    output logic      [N-1:0] req_n     // Requests, high when idle
);
    int unsigned cnt [N];
    // Back-off outlasts the grant release, so no master is re-served early
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < N; i++) begin
            if (!resetn) begin
                req_n[i] <= 1'h1;
                cnt[i] <= 0;
            end else if (req_n[i]) begin
                if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
                else if (want[i]) req_n[i] <= 1'h0;
            end else if (!gnt_n[i]) begin
                cnt[i] <= (cnt[i] == HOLD - 1) ? 5 : cnt[i] + 1;
                if (cnt[i] == HOLD - 1) req_n[i] <= 1'h1;
            end
        end
    end
endmodule : pss_bus_masters
`default_nettype wire

// ---- pss_idsel_map.sv ----
// Purpose: Decode config-cycle AD lines into per-device chip selects
// Assumes: AD sampled by the caller on the core clock
// Notes:   Pure combinational, registered by the parent
`timescale 1ns/1ps
`default_nettype none
module pss_idsel_map (
    input  wire logic [31:0] ad,           // Address/data bus
    input  wire logic        cfg_cycle,    // Configuration cycle in progress
    input  wire logic        raid_hide,    // Hide storage controller
    output logic      [4:0]  narrow_sel,   // Slot6,slot5,fasteth,gigabit,video
    output logic      [2:0]  storage_sel,  // Ctrl,slot3,slot4
    output logic             fast_sel      // Slot1
);

    // Narrow segment selects
    always_comb begin
        narrow_sel[4] = cfg_cycle & ad[pss_pkg::NARROW_IDSEL_SLOT6];   // R10 R9
        narrow_sel[3] = cfg_cycle & ad[pss_pkg::NARROW_IDSEL_SLOT5];   // R10
        narrow_sel[2] = cfg_cycle & ad[pss_pkg::NARROW_IDSEL_FASTETH]; // R10
        narrow_sel[1] = cfg_cycle & ad[pss_pkg::NARROW_IDSEL_GIGABIT]; // R10
        narrow_sel[0] = cfg_cycle & ad[pss_pkg::NARROW_IDSEL_VIDEO];   // R10
    end

    // Storage selects; controller hidden behind the RAID card
    always_comb begin
        storage_sel[2] = cfg_cycle & ad[pss_pkg::STORAGE_IDSEL_CTRL] & ~raid_hide; // R11 R8
        storage_sel[1] = cfg_cycle & ad[pss_pkg::STORAGE_IDSEL_SLOT3]; // R11
        storage_sel[0] = cfg_cycle & ad[pss_pkg::STORAGE_IDSEL_SLOT4]; // R11
    end

    // Fast segment select
    assign fast_sel = cfg_cycle & ad[pss_pkg::FAST_IDSEL_SLOT1]; // R12

endmodule : pss_idsel_map
`default_nettype wire

// ---- pss_pkg.sv ----
// Purpose: Shared constants for the PCI segment steering block
// Assumes: Single 40 MHz core clock, synchronous active-low reset
// Notes:   IDSEL bit numbers, grant pair counts and mode encodings
package pss_pkg;

    // Segment mode / speed encodings
    typedef enum logic [2:0] {
        pss_mode_pci33   = 3'b000,
        pss_mode_pci66   = 3'b001,
        pss_mode_pcix66  = 3'b010,
        pss_mode_pcix100 = 3'b011,
        pss_mode_pcix133 = 3'b100
    } pss_mode_t;

    // Narrow segment IDSEL address bits
    localparam int unsigned NARROW_IDSEL_SLOT6   = 24;
    localparam int unsigned NARROW_IDSEL_SLOT5   = 25;
    localparam int unsigned NARROW_IDSEL_FASTETH = 19;
    localparam int unsigned NARROW_IDSEL_GIGABIT = 20;
    localparam int unsigned NARROW_IDSEL_VIDEO   = 28;

    // Storage segment IDSEL address bits
    localparam int unsigned STORAGE_IDSEL_CTRL  = 19;
    localparam int unsigned STORAGE_IDSEL_SLOT3 = 18;
    localparam int unsigned STORAGE_IDSEL_SLOT4 = 17;

    // Fast segment IDSEL address bit
    localparam int unsigned FAST_IDSEL_SLOT1 = 18;

    // Arbitration pair counts (board-level pairs only)
    localparam int unsigned NARROW_PAIRS  = 5;
    localparam int unsigned STORAGE_PAIRS = 3;

    // Slot index that may carry the RAID steering card
    localparam int unsigned RAID_SLOT_NUM = 4;

    // Reset values
    localparam logic [4:0] NARROW_GNT_RST  = 5'h00;
    localparam logic [2:0] STORAGE_GNT_RST = 3'h0;

endpackage : pss_pkg

// ---- pss_rr_arb.sv ----
// Purpose: Round-robin arbiter with one-hot, registered grant
// Assumes: Requests active high, synchronous to core_clk
// Notes:   Pointer moves past the last winner so nobody starves
`timescale 1ns/1ps
`default_nettype none
module pss_rr_arb #(
    parameter int unsigned N = 5
) (
    input  wire logic         core_clk, // Core clock
    input  wire logic         resetn,   // Sync reset, active low
    input  wire logic [N-1:0] req,      // Requests
    output logic      [N-1:0] gnt_q     // One-hot grant
);
    logic [N-1:0] gnt_d;
    logic [N-1:0] last_q;

    // Pick first request after the last winner
    always_comb begin
        logic found;
        int unsigned idx;
        found = 1'b0;
        idx   = 0;
        gnt_d = '0;
        if ((gnt_q & req) != '0) begin
            gnt_d = gnt_q; // Hold while owner still requests
        end else begin
            for (int unsigned k = 1; k <= N; k++) begin
                idx = 0;
                for (int unsigned j = 0; j < N; j++) begin
                    if (last_q[j]) idx = (j + k) % N;
                end
                if (!found && req[idx]) begin
                    gnt_d[idx] = 1'b1; // R22
                    found = 1'b1;
                end
            end
        end
    end

    // Grant register, at most one bit set
    always_ff @(posedge core_clk) begin
        if (!resetn) gnt_q <= '0;
        else         gnt_q <= gnt_d; // R22
    end

    // Remember last winner for rotation
    always_ff @(posedge core_clk) begin
        if (!resetn)           last_q <= N'(1) << (N-1);
        else if (gnt_d != '0)  last_q <= gnt_d;
    end

endmodule : pss_rr_arb
`default_nettype wire

// ---- pss_segment_steering.sv ----
// Purpose: Steering for three PCI segments: IDSEL, arbitration, RAID
// Assumes: AD, config, request, RAID-present, disable and interrupt pins pass a two-flop synchroniser; mode pins and raid_card_slot do not
// Notes:   Mode/speed chosen by firmware; block validates and applies
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - Firmware: fast segment single card 133
// R2 - Firmware: fast segment two cards 100
// R3 - Firmware: storage segment PCI-X 100
// R4 - Mode never exceeds least capable card; code still applies pss_mode_pci66 when the cap is pss_mode_pci33
// R5 - RAID option allows storage segment PCI66
// R6 - RAID option honoured only in slot four
// R7 - RAID: storage interrupts go to card
// R8 - RAID: withhold storage controller chip select
// R9 - Each IDSEL from one upper AD bit
// R10 - Narrow segment IDSEL bit map
// R11 - Storage segment IDSEL bit map
// R12 - Fast segment slot one on bit 18
// R13 - Narrow arbiter serves all masters
// R14 - Narrow request/grant pair mapping
// R15 - Bridge own pair stays internal
// R16 - Storage arbiter pair mapping
// R17 - One disable output per embedded device
// R18 - Narrow segment PCI 32-bit 33
// R19 - Storage segment 100 or 66
// R20 - Fast segment 133, 100 or 66
// R21 - Segment clocks from common synthesizer
// R22 - One grant at a time, rotating
module pss_segment_steering (
    input  wire logic        core_clk,             // 40 MHz core clock
    input  wire logic        resetn,               // Sync reset, active low
    // Configuration-cycle decode inputs (pins)
    input  wire logic [31:0] narrow_ad,            // Narrow segment AD
    input  wire logic        narrow_cfg,           // Narrow config cycle
    input  wire logic [31:0] storage_ad,           // Storage segment AD
    input  wire logic        storage_cfg,          // Storage config cycle
    input  wire logic [31:0] fast_ad,              // Fast segment AD
    input  wire logic        fast_cfg,             // Fast config cycle
    // Narrow segment arbitration (active-low pins)
    input  wire logic        narrow_req_pair_four_n, // Slot 6 request
    input  wire logic        narrow_req_pair_three_n,// Slot 5 request
    input  wire logic        narrow_req_pair_two_n,  // Fast ethernet request
    input  wire logic        narrow_req_pair_one_n,  // Gigabit request
    input  wire logic        narrow_req_pair_zero_n, // Video request
    output logic             narrow_gnt_pair_four_n, // Slot 6 grant
    output logic             narrow_gnt_pair_three_n,// Slot 5 grant
    output logic             narrow_gnt_pair_two_n,  // Fast ethernet grant
    output logic             narrow_gnt_pair_one_n,  // Gigabit grant
    output logic             narrow_gnt_pair_zero_n, // Video grant
    // Storage segment arbitration
    input  wire logic        storage_seg_req_two_n,  // Storage ctrl request
    input  wire logic        storage_seg_req_one_n,  // Slot 3 request
    input  wire logic        storage_seg_req_zero_n, // Slot 4 request
    output logic             storage_seg_gnt_two_n,  // Storage ctrl grant
    output logic             storage_seg_gnt_one_n,  // Slot 3 grant
    output logic             storage_seg_gnt_zero_n, // Slot 4 grant
    // Chip selects
    output logic      [4:0]  narrow_idsel_q,       // Slot6,slot5,fe,gig,video
    output logic      [2:0]  storage_idsel_q,      // Ctrl,slot3,slot4
    output logic             fast_idsel_q,         // Slot 1
    // RAID steering
    input  wire logic        raid_card_present,    // RAID card detected
    input  wire logic [2:0]  raid_card_slot,       // Slot holding RAID card
    input  wire logic        storage_irq_n,        // Storage ctrl interrupt
    output logic             raid_irq_n,           // Interrupt to RAID card
    output logic             sys_storage_irq_n,    // Interrupt to system
    // Firmware mode control
    input  wire logic [2:0]  storage_mode_req,     // Requested storage mode
    input  wire logic [2:0]  storage_cap,          // Least capable card mode
    input  wire logic [2:0]  fast_mode_req,        // Requested fast mode
    input  wire logic [2:0]  fast_cap,             // Least capable card mode
    output logic      [2:0]  storage_mode_q,       // Applied storage mode
    output logic      [2:0]  fast_mode_q,          // Applied fast mode
    output logic      [2:0]  narrow_mode_q,        // Narrow mode (fixed)
    // Device disables
    input  wire logic [2:0]  dev_disable_req,      // Video, gigabit, fasteth
    output logic             video_disable_q,      // Disable video
    output logic             gigabit_disable_q,    // Disable gigabit
    output logic             fast_ethernet_disable_q // Disable fast ethernet
);

    // Synchroniser stage registers
    logic [31:0] n_ad_s1, n_ad_s2, s_ad_s1, s_ad_s2, f_ad_s1, f_ad_s2;
    logic [2:0]  cfg_s1, cfg_s2;
    logic [4:0]  nreq_s1, nreq_s2;
    logic [2:0]  sreq_s1, sreq_s2;
    logic [4:0]  raid_s1, raid_s2;
    logic        irq_s1, irq_s2;
    logic [4:0]  narrow_gnt;
    logic [2:0]  storage_gnt;
    logic [4:0]  narrow_sel;
    logic [2:0]  storage_sel;
    logic        fast_sel;
    logic        raid_hide;

    // Clamp request to capability and allowed set
    function automatic logic [2:0] pss_clamp(input logic [2:0] req,
                                             input logic [2:0] cap,
                                             input logic [2:0] top);
        logic [2:0] v;
        v = req;
        if (v > cap) v = cap;   // Least capable card governs
        if (v > top) v = top;
        if (v == 3'h0) v = 3'h1; // Wide segments never drop to 33
        return v;
    endfunction : pss_clamp

    // Pin synchronisers, first stage feeds only second stage
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            n_ad_s1 <= 32'h0;
            n_ad_s2 <= 32'h0;
            s_ad_s1 <= 32'h0;
            s_ad_s2 <= 32'h0;
            f_ad_s1 <= 32'h0;
            f_ad_s2 <= 32'h0;
        end else begin
            n_ad_s1 <= narrow_ad;
            n_ad_s2 <= n_ad_s1;
            s_ad_s1 <= storage_ad;
            s_ad_s2 <= s_ad_s1;
            f_ad_s1 <= fast_ad;
            f_ad_s2 <= f_ad_s1;
        end
    end

    // Control pin synchronisers; requests idle high
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cfg_s1  <= 3'h0;
            cfg_s2  <= 3'h0;
            nreq_s1 <= 5'h1f;
            nreq_s2 <= 5'h1f;
            sreq_s1 <= 3'h7;
            sreq_s2 <= 3'h7;
            raid_s1 <= 5'h00;
            raid_s2 <= 5'h00;
            irq_s1  <= 1'b1;
            irq_s2  <= 1'b1;
        end else begin
            cfg_s1  <= {narrow_cfg, storage_cfg, fast_cfg};
            cfg_s2  <= cfg_s1;
            nreq_s1 <= {narrow_req_pair_four_n, narrow_req_pair_three_n,
                        narrow_req_pair_two_n, narrow_req_pair_one_n,
                        narrow_req_pair_zero_n};
            nreq_s2 <= nreq_s1;
            sreq_s1 <= {storage_seg_req_two_n, storage_seg_req_one_n,
                        storage_seg_req_zero_n};
            sreq_s2 <= sreq_s1;
            raid_s1 <= {raid_card_present, dev_disable_req, 1'b0};
            raid_s2 <= raid_s1;
            irq_s1  <= storage_irq_n;
            irq_s2  <= irq_s1;
        end
    end

    // RAID option honoured only in its one slot
    assign raid_hide = raid_s2[4] &&
                       (raid_card_slot == 3'(pss_pkg::RAID_SLOT_NUM)); // R6

    // IDSEL decode, one AD bit each
    pss_idsel_map u_idsel (
        .ad          (n_ad_s2),
        .cfg_cycle   (cfg_s2[2]),
        .raid_hide   (1'b0),
        .narrow_sel  (narrow_sel),
        .storage_sel (),
        .fast_sel    ()
    );

    pss_idsel_map u_idsel_wide (
        .ad          (s_ad_s2),
        .cfg_cycle   (cfg_s2[1]),
        .raid_hide   (raid_hide),
        .narrow_sel  (),
        .storage_sel (storage_sel),
        .fast_sel    ()
    );

    // Fast segment select decoded locally
    assign fast_sel = cfg_s2[0] & f_ad_s2[pss_pkg::FAST_IDSEL_SLOT1]; // R12

    // Registered chip selects
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            narrow_idsel_q  <= 5'h00;
            storage_idsel_q <= 3'h0;
            fast_idsel_q    <= 1'b0;
        end else begin
            narrow_idsel_q  <= narrow_sel;  // R9 R10
            storage_idsel_q <= storage_sel; // R11 R8
            fast_idsel_q    <= fast_sel;    // R12
        end
    end

    // Narrow arbiter: five board pairs, bridge pair kept internal
    pss_rr_arb #(.N(pss_pkg::NARROW_PAIRS)) u_narrow_arb (
        .core_clk (core_clk),
        .resetn   (resetn),
        .req      (~nreq_s2),   // R13 R14
        .gnt_q    (narrow_gnt)
    );

    // Storage arbiter: three board pairs
    pss_rr_arb #(.N(pss_pkg::STORAGE_PAIRS)) u_storage_arb (
        .core_clk (core_clk),
        .resetn   (resetn),
        .req      (~sreq_s2),   // R16
        .gnt_q    (storage_gnt)
    );

    // Grants drive pins active low; index equals pair number
    always_comb begin
        narrow_gnt_pair_four_n  = ~narrow_gnt[4]; // R14
        narrow_gnt_pair_three_n = ~narrow_gnt[3]; // R14
        narrow_gnt_pair_two_n   = ~narrow_gnt[2]; // R14
        narrow_gnt_pair_one_n   = ~narrow_gnt[1]; // R14
        narrow_gnt_pair_zero_n  = ~narrow_gnt[0]; // R14 R15
        storage_seg_gnt_two_n   = ~storage_gnt[2]; // R16
        storage_seg_gnt_one_n   = ~storage_gnt[1]; // R16
        storage_seg_gnt_zero_n  = ~storage_gnt[0]; // R16 R15
    end

    // Interrupt steering: card takes them when present in slot four
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            raid_irq_n        <= 1'b1;
            sys_storage_irq_n <= 1'b1;
        end else begin
            raid_irq_n        <= raid_hide ? irq_s2 : 1'b1; // R7
            sys_storage_irq_n <= raid_hide ? 1'b1 : irq_s2; // R7
        end
    end

    // Applied segment modes; synthesizer clocks all segments
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            narrow_mode_q  <= pss_pkg::pss_mode_pci33;
            storage_mode_q <= pss_pkg::pss_mode_pcix100;
            fast_mode_q    <= pss_pkg::pss_mode_pcix133;
        end else begin
            narrow_mode_q  <= pss_pkg::pss_mode_pci33; // R18 R21
            storage_mode_q <= (raid_hide && storage_mode_req == pss_pkg::pss_mode_pci66) ?
                              pss_pkg::pss_mode_pci66 : // R5
                              pss_clamp(storage_mode_req, storage_cap,
                                        pss_pkg::pss_mode_pcix100); // R19 R4 R3
            fast_mode_q    <= pss_clamp(fast_mode_req, fast_cap,
                                        pss_pkg::pss_mode_pcix133); // R20 R4 R1 R2
        end
    end

    // Embedded device disables, one per device
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            video_disable_q         <= 1'b0;
            gigabit_disable_q       <= 1'b0;
            fast_ethernet_disable_q <= 1'b0;
        end else begin
            video_disable_q         <= raid_s2[3]; // R17
            gigabit_disable_q       <= raid_s2[2]; // R17
            fast_ethernet_disable_q <= raid_s2[1]; // R17
        end
    end

endmodule : pss_segment_steering
`default_nettype wire

// ---- pss_segment_steering_properties.sv ----
// Purpose: Concurrent checks on the segment steering block ports
// Assumes: Synced inputs reach outputs three edges later
// Notes:   Checks wait a few edges after reset while sync flops refill
`timescale 1ns/1ps
`default_nettype none
module pss_segment_steering_properties (
    input wire logic        core_clk,                // Core clock
    input wire logic        resetn,                  // Sync reset
    input wire logic [31:0] narrow_ad,               // Narrow AD
    input wire logic        narrow_cfg,              // Config cycle
    input wire logic        narrow_req_pair_four_n,  // Slot 6 req
    input wire logic        narrow_req_pair_three_n, // Slot 5 req
    input wire logic        narrow_req_pair_two_n,   // Fast eth req
    input wire logic        narrow_req_pair_one_n,   // Gigabit req
    input wire logic        narrow_req_pair_zero_n,  // Video req
    input wire logic        narrow_gnt_pair_four_n,  // Slot 6 gnt
    input wire logic        narrow_gnt_pair_three_n, // Slot 5 gnt
    input wire logic        narrow_gnt_pair_two_n,   // Fast eth gnt
    input wire logic        narrow_gnt_pair_one_n,   // Gigabit gnt
    input wire logic        narrow_gnt_pair_zero_n,  // Video gnt
    input wire logic [4:0]  narrow_idsel_q,          // Chip selects
    input wire logic        raid_card_present,       // Card seen
    input wire logic [2:0]  raid_card_slot,          // Card slot
    input wire logic        storage_irq_n,           // Storage irq
    input wire logic        raid_irq_n,              // Irq to card
    input wire logic        sys_storage_irq_n,       // Irq to system
    input wire logic [2:0]  fast_mode_req,           // Fast request
    input wire logic [2:0]  fast_cap,                // Fast limit
    input wire logic [2:0]  fast_mode_q,             // Fast applied
    input wire logic [2:0]  narrow_mode_q,           // Narrow mode
    input wire logic [2:0]  dev_disable_req,         // Disable reqs
    input wire logic        video_disable_q          // Video off
);
    logic [2:0] up_q;
    logic       ready, hide;
    logic [4:0] req_n, gnt_n, sel_now;
    // Gathered views; slot static, so hiding is a level
    assign ready = up_q >= 3'h4;
    assign hide = raid_card_present && raid_card_slot == 3'h4;
    assign req_n = {narrow_req_pair_four_n, narrow_req_pair_three_n, narrow_req_pair_two_n,
                    narrow_req_pair_one_n, narrow_req_pair_zero_n};
    assign gnt_n = {narrow_gnt_pair_four_n, narrow_gnt_pair_three_n, narrow_gnt_pair_two_n,
                    narrow_gnt_pair_one_n, narrow_gnt_pair_zero_n};
    assign sel_now = {5{narrow_cfg}} & {narrow_ad[24], narrow_ad[25], narrow_ad[19],
                                        narrow_ad[20], narrow_ad[28]};
    // Saturating count masks refill after reset
    always_ff @(posedge core_clk) begin
        if (!resetn) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    // Fast mode limit, floor at 66
    function automatic logic [2:0] fclamp(input logic [2:0] r, input logic [2:0] c);
        logic [2:0] m;
        m = (r < c) ? r : c;
        if (m > 3'h4) m = 3'h4;
        if (m < 3'h1) m = 3'h1;
        return m;
    endfunction : fclamp
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    narrow_idsel_a: assert property (
        ready |-> narrow_idsel_q == $past(sel_now, 3)) else $error("narrow select wrong");
    grant_single_a: assert property (
        ready |-> $onehot0(~gnt_n)) else $error("two grants at once");
    grant_cause_a: assert property (
        ready && gnt_n != 5'h1f |-> (~gnt_n & $past(req_n, 3)) == 5'h0)
        else $error("grant without request");
    raid_irq_a: assert property (
        ready && hide |-> ##3 raid_irq_n == $past(storage_irq_n, 3) && sys_storage_irq_n)
        else $error("irq not steered to card");
    sys_irq_a: assert property (
        ready && !hide |-> raid_irq_n && sys_storage_irq_n == $past(storage_irq_n, 3))
        else $error("irq not sent to system");
    fast_mode_a: assert property (
        ready |-> fast_mode_q == fclamp($past(fast_mode_req), $past(fast_cap)))
        else $error("fast mode wrong");
    narrow_mode_a: assert property (
        ready |-> narrow_mode_q == 3'h0 && $stable(narrow_mode_q)) else $error("narrow mode");
    video_off_a: assert property (
        ready && $rose(dev_disable_req[2]) |-> ##2 !video_disable_q ##1 video_disable_q)
        else $error("video disable late");
endmodule : pss_segment_steering_properties
bind pss_segment_steering pss_segment_steering_properties chk (.*);
`default_nettype wire

// ---- test_pss_segment_steering.sv ----
// Purpose: Self-checking bench for the segment steering block
// Assumes: Inputs move 1 ns after each rising edge
// Notes:   RAID slot only changes under reset, as the block expects
`timescale 1ns/1ps
`default_nettype none
module test_pss_segment_steering;
    logic        core_clk = 1'h0, resetn = 1'h0, storage_irq_n = 1'h1, fast_ethernet_disable_q;
    logic        narrow_cfg = 1'h0, storage_cfg = 1'h0, fast_cfg = 1'h0, raid_card_present = 1'h0;
    logic [31:0] narrow_ad = 32'h0, storage_ad = 32'h0, fast_ad = 32'h0;
    logic [2:0]  raid_card_slot = 3'h0, dev_disable_req = 3'h0, storage_mode_req = 3'h3;
    logic [2:0]  storage_cap = 3'h4, fast_mode_req = 3'h4, fast_cap = 3'h4, swant = 3'h0;
    logic [2:0]  sprev = 3'h7, sgnt_n, sreq_n, storage_idsel_q, storage_mode_q;
    logic [2:0]  fast_mode_q, narrow_mode_q;
    logic [4:0]  nwant = 5'h0, nprev = 5'h1f, ngnt_n, nreq_n, narrow_idsel_q;
    logic        fast_idsel_q, raid_irq_n, sys_storage_irq_n, video_disable_q, gigabit_disable_q;
    int          fail_count = 0, checks = 0, nord [$], sord [$];
    pss_segment_steering DUT (.*, .narrow_req_pair_four_n(nreq_n[4]),
        .narrow_req_pair_three_n(nreq_n[3]), .narrow_req_pair_two_n(nreq_n[2]),
        .narrow_req_pair_one_n(nreq_n[1]), .narrow_req_pair_zero_n(nreq_n[0]),
        .narrow_gnt_pair_four_n(ngnt_n[4]), .narrow_gnt_pair_three_n(ngnt_n[3]),
        .narrow_gnt_pair_two_n(ngnt_n[2]), .narrow_gnt_pair_one_n(ngnt_n[1]),
        .narrow_gnt_pair_zero_n(ngnt_n[0]), .storage_seg_req_two_n(sreq_n[2]),
        .storage_seg_req_one_n(sreq_n[1]), .storage_seg_req_zero_n(sreq_n[0]),
        .storage_seg_gnt_two_n(sgnt_n[2]), .storage_seg_gnt_one_n(sgnt_n[1]),
        .storage_seg_gnt_zero_n(sgnt_n[0]));
    // Quick narrow masters, slow storage ones
    pss_bus_masters #(.N(5), .HOLD(4)) narrow_masters (.*, .want(nwant),
        .gnt_n(ngnt_n), .req_n(nreq_n));
    pss_bus_masters #(.N(3), .HOLD(9)) storage_masters (.*, .want(swant),
        .gnt_n(sgnt_n), .req_n(sreq_n));
    always #12.5 core_clk = ~core_clk;
    // Log each new grant owner on the settled falling edge
    always @(negedge core_clk) begin
        for (int i = 0; i < 5; i++) if (!ngnt_n[i] && nprev[i]) nord.push_back(i);
        for (int i = 0; i < 3; i++) if (!sgnt_n[i] && sprev[i]) sord.push_back(i);
        nprev = ngnt_n;
        sprev = sgnt_n;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic [2:0] slot, input logic present);
        {resetn, raid_card_slot, raid_card_present} = {1'h0, slot, present};
        step(8);
        check({ngnt_n, sgnt_n, narrow_idsel_q, storage_idsel_q, fast_idsel_q, raid_irq_n,
               sys_storage_irq_n, video_disable_q, gigabit_disable_q, fast_ethernet_disable_q},
              {8'hff, 9'h000, 2'h3, 3'h0});
        check({narrow_mode_q, storage_mode_q, fast_mode_q}, 9'h01c);
        resetn = 1'h1;
        step(6);
        $display("reset done");
    endtask : do_reset
    task automatic t_idsel;
        for (int b = 16; b < 32; b++) begin
            {narrow_ad, storage_ad, fast_ad} = {3{32'h1 << b}};
            {narrow_cfg, storage_cfg, fast_cfg} = 3'h7;
            step(4);
            check(narrow_idsel_q, {b == 24, b == 25, b == 19, b == 20, b == 28});
            check(storage_idsel_q, {b == 19, b == 18, b == 17});
            check(fast_idsel_q, b == 18);
        end
        {narrow_ad, storage_ad, fast_ad} = {96{1'h1}};
        {narrow_cfg, storage_cfg, fast_cfg} = 3'h0;
        step(4);
        check({narrow_idsel_q, storage_idsel_q, fast_idsel_q}, 9'h000);
        $display("idsel done");
    endtask : t_idsel
    task automatic t_modes;
        logic [11:0] ft [4] = '{12'h444, 12'h343, 12'h422, 12'h411};
        logic [11:0] st [4] = '{12'h343, 12'h443, 12'h322, 12'h232};
        for (int i = 0; i < 4; i++) begin
            {fast_mode_req, fast_cap} = {ft[i][10:8], ft[i][6:4]};
            {storage_mode_req, storage_cap} = {st[i][10:8], st[i][6:4]};
            step(2);
            check(fast_mode_q, ft[i][2:0]);
            check(storage_mode_q, st[i][2:0]);
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_disable;
        for (int i = 0; i < 3; i++) begin
            dev_disable_req = 3'h1 << i;
            step(4);
            check({video_disable_q, gigabit_disable_q, fast_ethernet_disable_q}, 3'h1 << i);
        end
        dev_disable_req = 3'h0;
        $display("disable done");
    endtask : t_disable
    task automatic t_arb;
        {nwant, swant} = 8'hff;
        step(60);
        {nwant, swant} = 8'h00;
        step(40);
        check(nord.size() > 6 && sord.size() > 3, 1'h1);
        foreach (nord[i]) check(nord[i], i % 5);
        foreach (sord[i]) check(sord[i], i % 3);
        $display("arb done");
    endtask : t_arb
    task automatic t_raid(input logic [2:0] slot, input logic present);
        logic hidden = present && slot == 3'h4;
        do_reset(slot, present);
        {storage_ad, storage_cfg, storage_mode_req, storage_cap} = {32'h80000, 1'h1, 3'h1, 3'h4};
        for (int k = 0; k < 2; k++) begin
            storage_irq_n = k[0];
            step(5);
            check({raid_irq_n, sys_storage_irq_n}, hidden ? {k[0], 1'h1} : {1'h1, k[0]});
        end
        check(storage_idsel_q[2], !hidden);
        if (hidden) check(storage_mode_q, 3'h1);
        $display("raid done");
    endtask : t_raid
    initial begin
        do_reset(3'h0, 1'h0);
        t_idsel();
        t_modes();
        t_disable();
        t_arb();
        t_raid(3'h4, 1'h0);
        t_raid(3'h3, 1'h1);
        t_raid(3'h4, 1'h1);
        wrap_up();
    end
    // Whole run needs about 275 cycles
    initial begin
        #(2000 * 25);
        fail_count++;
        wrap_up();
    end
endmodule : test_pss_segment_steering
`default_nettype wire
